// [rtl/exception_unit.sv]
// Interrupt arbitration, instruction exceptions and stacking sequencer
// Contract
// RULE1: Priority levels run 0 to 16, higher number wins arbitration.
// RULE2: Non-maskable interrupt is level 16, accepted whatever the mask.
// RULE3: User break and debug requests have fixed level 15.
// RULE4: Encoded level request takes level 1-15 from the encoded pins.
// RULE5: External lines and peripherals get software levels 0-15 only.
// RULE6: Maskable interrupt accepted only if level exceeds mask field.
// RULE7: Among simultaneous requests the highest level is served first.
// RULE8: Accepting an interrupt pushes status word, then program counter.
// RULE9: After stacking, mask takes accepted level; non-maskable writes 15.
// RULE10: Handler address read from the vector table, then jumped to.
// RULE11: Every source owns a distinct vector number and table offset.
// RULE12: Sources: non-maskable, break, debug, 15 levels, 4 lines, peripherals.
// RULE13: Trap pushes status word, then address after the trap.
// RULE14: Trap vector comes from the instruction; jump has no delay slot.
// RULE15: Undefined code in delay slot starts slot exception at decode.
// RULE16: PC-changing instruction in delay slot also starts slot exception.
// RULE17: Slot exception pushes the preceding delayed branch target.
// RULE18: Undefined code elsewhere pushes the undefined code's own address.
// RULE19: Exactly ten instructions count as delayed branches for the slot.
// RULE20: Each push decrements the stack pointer by 4 before writing.
// RULE21: Vector entry is a word at vector base plus four times vector.
// RULE22: Instruction exceptions beat a coinciding interrupt.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "exc_defs.svh"
module exception_unit #(
	parameter int NPERIPH = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt requests
	input wire logic nmiPin,
	input wire logic userBreakReq,
	input wire logic debugInterfaceReq,
	input wire logic [3:0] encodedLevelPins,
	input wire logic [3:0] extLineReq,
	input wire logic [NPERIPH-1:0] periphReq,
	// Decode stage
	input wire exc_pkg::dec_t dec,
	// Memory port for stacking and vector fetch
	output exc_pkg::mem_req_t mem,
	input wire logic memAck,
	input wire logic [31:0] memRdata,
	// Results
	output logic intAck,
	output logic [7:0] ackVector,
	output logic busy,
	output logic redirectValid,
	output logic [31:0] redirectPc,
	output logic [31:0] statusWord
);
	// Peripheral priorities share one 32-bit register
	if (NPERIPH < 1 || NPERIPH > 8) begin : gNperiphCheck
		$error("NPERIPH must be 1 to 8");
	end

	exc_pkg::state_t state_r;
	exc_pkg::mem_req_t mem_r;
	logic [31:0] statusWord_r;
	logic [31:0] stackPtr_r;
	logic [31:0] vecBase_r;
	logic [15:0] extPrio_r;
	logic [31:0] periphPrio_r;
	logic [31:0] retPc_r;
	logic [7:0] vec_r;
	logic [3:0] newMask_r;
	logic isInt_r;
	logic nmiPrev_r;
	logic nmiPend_r;
	logic intAck_r;
	logic [7:0] ackVector_r;
	logic busy_r;
	logic redirectValid_r;
	logic [31:0] redirectPc_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// Vector table entry address
	function automatic logic [31:0] vecAddr(
		input logic [31:0] base,
		input logic [7:0] v
	);
		// RULE21: base plus four times
		vecAddr = base + {22'h0, v, 2'b00};
	endfunction : vecAddr

	function automatic logic [7:0] addVec(
		input logic [7:0] base,
		input int idx
	);
		addVec = base + 8'(idx);
	endfunction : addVec

	// Arbitration over all maskable sources
	exc_pkg::win_t win;
	logic [3:0] mask;
	logic nmiTake;
	logic intTake;
	logic instrExc;
	logic [7:0] instrVec;
	logic [31:0] instrRet;
	logic apbWr;
	logic apbRd;
	logic [31:0] unitState;

	assign mask = statusWord_r[`MASK_MSB:`MASK_LSB];

	always_comb begin
		win = '0;
		// RULE3: break and debug fixed at 15
		if (userBreakReq) begin
			win = '{level: `LVL_FIXED, vector: `VEC_BREAK, hit: 1'b1};
		end else if (debugInterfaceReq) begin
			win = '{level: `LVL_FIXED, vector: `VEC_DEBUG, hit: 1'b1};
		end
		// RULE4: level straight from pins
		if (encodedLevelPins != 4'h0 &&
		    {1'b0, encodedLevelPins} > win.level) begin
			win.level = {1'b0, encodedLevelPins};
			// RULE11: one vector per level
			win.vector = addVec(`VEC_LEVEL_BASE,
			    int'(encodedLevelPins));
			win.hit = 1'b1;
		end
		// RULE12: four external lines
		for (int i = 0; i < 4; i++) begin
			// RULE1: larger level wins
			if (extLineReq[i] &&
			    (!win.hit || {1'b0, extPrio_r[i*4 +: 4]} > win.level)) begin
				win.level = {1'b0, extPrio_r[i*4 +: 4]};
				win.vector = addVec(`VEC_LINE_BASE, i);
				win.hit = 1'b1;
			end
		end
		for (int i = 0; i < NPERIPH; i++) begin
			if (periphReq[i] &&
			    (!win.hit ||
			     {1'b0, periphPrio_r[i*4 +: 4]} > win.level)) begin
				win.level = {1'b0, periphPrio_r[i*4 +: 4]};
				win.vector = addVec(`VEC_PERIPH_BASE, i);
				win.hit = 1'b1;
			end
		end
	end

	always_comb begin
		// RULE19: slot flag marks the ten delayed branches
		// RULE15: undefined code in slot
		// RULE16: PC writer in slot
		instrExc = dec.valid &&
		    (dec.trap || dec.undefined || (dec.inSlot && dec.pcWrite));
		instrVec = `VEC_ILLEGAL;
		instrRet = dec.pc;
		if (dec.inSlot && (dec.undefined || dec.pcWrite)) begin
			instrVec = `VEC_SLOT;
			// RULE17: push delayed branch target
			instrRet = dec.slotTarget;
		end else if (dec.undefined) begin
			// RULE18: own start address
			instrVec = `VEC_ILLEGAL;
			instrRet = dec.pc;
		end else if (dec.trap) begin
			// RULE13: address after the trap
			instrVec = dec.trapVec;
			instrRet = dec.nextPc;
		end
	end

	// Interrupts wait for an instruction boundary outside a slot
	// RULE2: non-maskable ignores mask
	assign nmiTake = nmiPend_r && dec.valid && !dec.inSlot;
	// RULE6: strictly above mask
	// RULE7: winner of arbitration goes first
	assign intTake = win.hit && win.level > {1'b0, mask} &&
	    dec.valid && !dec.inSlot;

	// Edge of the non-maskable pin is held until serviced
	always_ff @(posedge core_clk) begin
		if (reset) begin
			nmiPrev_r <= 1'b0;
			nmiPend_r <= 1'b0;
		end else begin
			nmiPrev_r <= nmiPin;
			// New edge wins over service clear
			if (nmiPin && !nmiPrev_r) begin
				nmiPend_r <= 1'b1;
			end else if (state_r == exc_pkg::IDLE && !instrExc &&
			    nmiTake) begin
				nmiPend_r <= 1'b0;
			end
		end
	end

	assign apbWr = psel && penable && pwrite && pready_r;
	assign apbRd = psel && penable && !pready_r;

	// Sequencer with stacking and vector fetch
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= exc_pkg::IDLE;
			mem_r <= '0;
			retPc_r <= 32'h0;
			vec_r <= 8'h0;
			newMask_r <= 4'h0;
			isInt_r <= 1'b0;
			intAck_r <= 1'b0;
			ackVector_r <= 8'h0;
			redirectValid_r <= 1'b0;
			redirectPc_r <= 32'h0;
			busy_r <= 1'b0;
		end else begin
			intAck_r <= 1'b0;
			redirectValid_r <= 1'b0;
			case (state_r)
				exc_pkg::IDLE: begin
					// RULE22: instruction exception first
					if (instrExc || nmiTake || intTake) begin
						state_r <= exc_pkg::PUSH_SR;
						busy_r <= 1'b1;
						// RULE8: status word first
						// RULE20: decrement before write
						mem_r <= '{req: 1'b1, we: 1'b1,
						    addr: stackPtr_r - `STACK_STEP,
						    wdata: statusWord_r};
						if (instrExc) begin
							isInt_r <= 1'b0;
							vec_r <= instrVec;
							retPc_r <= instrRet;
						end else begin
							isInt_r <= 1'b1;
							retPc_r <= dec.pc;
							intAck_r <= 1'b1;
							if (nmiTake) begin
								vec_r <= `VEC_NMI;
								ackVector_r <= `VEC_NMI;
								newMask_r <= `MASK_NMI;
							end else begin
								vec_r <= win.vector;
								ackVector_r <= win.vector;
								newMask_r <= win.level[3:0];
							end
						end
					end
				end
				exc_pkg::PUSH_SR: begin
					if (memAck) begin
						state_r <= exc_pkg::PUSH_PC;
						// RULE20: second decrement
						mem_r.addr <= stackPtr_r - `STACK_STEP;
						mem_r.wdata <= retPc_r;
					end
				end
				exc_pkg::PUSH_PC: begin
					if (memAck) begin
						state_r <= exc_pkg::FETCH_VEC;
						mem_r.we <= 1'b0;
						mem_r.wdata <= 32'h0;
						// RULE10: read table entry
						// RULE14: trap vector from instruction
						mem_r.addr <= vecAddr(vecBase_r, vec_r);
					end
				end
				exc_pkg::FETCH_VEC: begin
					if (memAck) begin
						state_r <= exc_pkg::IDLE;
						mem_r <= '0;
						busy_r <= 1'b0;
						// RULE14: immediate jump, no slot
						redirectValid_r <= 1'b1;
						redirectPc_r <= memRdata;
					end
				end
				default: begin
					state_r <= exc_pkg::IDLE;
					mem_r <= '0;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// Status word and stack pointer; hardware update wins over software
	always_ff @(posedge core_clk) begin
		if (reset) begin
			statusWord_r <= `RST_STATUS_WORD;
			stackPtr_r <= `RST_STACK_PTR;
		end else begin
			if (apbWr && paddr[7:0] == `OFS_STATUS_WORD) begin
				statusWord_r <= pwdata;
			end
			if (apbWr && paddr[7:0] == `OFS_STACK_PTR) begin
				stackPtr_r <= pwdata;
			end
			// RULE20: each push moves the pointer
			if (state_r == exc_pkg::IDLE &&
			    (instrExc || nmiTake || intTake)) begin
				stackPtr_r <= stackPtr_r - `STACK_STEP;
			end else if (state_r == exc_pkg::PUSH_SR && memAck) begin
				stackPtr_r <= stackPtr_r - `STACK_STEP;
			end
			// RULE9: mask written after stacking
			if (state_r == exc_pkg::PUSH_PC && memAck && isInt_r) begin
				statusWord_r[`MASK_MSB:`MASK_LSB] <= newMask_r;
			end
		end
	end

	// Programmable priorities, four bits each so level 16 cannot occur
	always_ff @(posedge core_clk) begin
		if (reset) begin
			vecBase_r <= `RST_VEC_BASE;
			extPrio_r <= 16'h0;
			periphPrio_r <= 32'h0;
		end else if (apbWr) begin
			case (paddr[7:0])
				`OFS_VEC_BASE: vecBase_r <= pwdata;
				// RULE5: only 0 to 15 storable
				`OFS_EXT_PRIO: extPrio_r <= pwdata[15:0];
				`OFS_PERIPH_PRIO: periphPrio_r <= pwdata;
				default: begin
				end
			endcase
		end
	end

	// Four states fit the two-bit state field
	assign unitState = {8'h0, ackVector_r, 7'h0, nmiPend_r,
	    mask, 1'b0, busy_r, state_r[1:0]};

	// APB answer one cycle into the access phase
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= apbRd;
			pslverr_r <= 1'b0;
			if (apbRd) begin
				prdata_r <= 32'h0;
				if (paddr[31:8] != 24'h0 || paddr[1:0] != 2'b00) begin
					pslverr_r <= 1'b1;
				end else begin
					case (paddr[7:0])
						`OFS_STATUS_WORD: prdata_r <= statusWord_r;
						`OFS_STACK_PTR: prdata_r <= stackPtr_r;
						`OFS_VEC_BASE: prdata_r <= vecBase_r;
						`OFS_EXT_PRIO: prdata_r <= {16'h0, extPrio_r};
						`OFS_PERIPH_PRIO: prdata_r <= periphPrio_r;
						`OFS_UNIT_STATE: prdata_r <= unitState;
						default: pslverr_r <= 1'b1;
					endcase
				end
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign mem = mem_r;
	assign intAck = intAck_r;
	assign ackVector = ackVector_r;
	assign busy = busy_r;
	assign redirectValid = redirectValid_r;
	assign redirectPc = redirectPc_r;
	assign statusWord = statusWord_r;
endmodule : exception_unit

// [rtl/exc_defs.svh]
// Offsets, field positions, reset values and vector numbers
`ifndef EXC_DEFS_SVH
`define EXC_DEFS_SVH
`define OFS_STATUS_WORD 8'h00
`define OFS_STACK_PTR 8'h04
`define OFS_VEC_BASE 8'h08
`define OFS_EXT_PRIO 8'h0c
`define OFS_PERIPH_PRIO 8'h10
`define OFS_UNIT_STATE 8'h14
`define MASK_LSB 4
`define MASK_MSB 7
`define RST_STATUS_WORD 32'h0000_00f0
`define RST_STACK_PTR 32'h0000_0000
`define RST_VEC_BASE 32'h0000_0000
`define LVL_NMI 5'h10
`define LVL_FIXED 5'h0f
`define MASK_NMI 4'hf
`define VEC_ILLEGAL 8'h04
`define VEC_SLOT 8'h06
`define VEC_NMI 8'h0b
`define VEC_BREAK 8'h0c
`define VEC_DEBUG 8'h0e
`define VEC_LEVEL_BASE 8'h40
`define VEC_LINE_BASE 8'h50
`define VEC_PERIPH_BASE 8'h60
`define STACK_STEP 32'h0000_0004
`endif

// [rtl/exc_pkg.sv]
// Types shared by the exception unit and its bench
package exc_pkg;
	typedef enum logic [2:0] {
		IDLE, PUSH_SR, PUSH_PC, FETCH_VEC
	} state_t;
	typedef struct packed {
		logic valid;
		logic undefined;
		logic pcWrite;
		logic trap;
		logic inSlot;
		logic [7:0] trapVec;
		logic [31:0] pc;
		logic [31:0] nextPc;
		logic [31:0] slotTarget;
	} dec_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_t;
	typedef struct packed {
		logic [4:0] level;
		logic [7:0] vector;
		logic hit;
	} win_t;
endpackage : exc_pkg

// [sim/exception_unit_properties.sv]
// Port assertions for the exception unit
`timescale 1ns/1ps
module exception_unit_properties (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Decode and memory
	input wire exc_pkg::dec_t dec,
	input wire exc_pkg::mem_req_t mem,
	input wire logic memAck,
	input wire logic [31:0] memRdata,
	// Results
	input wire logic intAck,
	input wire logic [7:0] ackVector,
	input wire logic busy,
	input wire logic redirectValid,
	input wire logic [31:0] redirectPc,
	input wire logic [31:0] statusWord
);
	logic intRun_r;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);
	always_ff @(posedge core_clk) begin
		if (reset || redirectValid) begin
			intRun_r <= 1'b0;
		end else if (intAck) begin
			intRun_r <= 1'b1;
		end
	end
	property p_gate;
		intAck && ackVector[7:4] == 4'h4 |->
			ackVector[3:0] > $past(statusWord[7:4]);
	endproperty
	a_gate: assert property (p_gate) else $error("mask gate");
	property p_first;
		intAck |-> $past(dec.valid && !dec.inSlot && !dec.undefined
			&& !dec.trap);
	endproperty
	a_first: assert property (p_first) else $error("int first");
	property p_push;
		$rose(busy) |-> mem.req && mem.we;
	endproperty
	a_push: assert property (p_push) else $error("push");
	property p_step;
		mem.req && mem.we && memAck ##1 mem.req && mem.we |->
			mem.addr == $past(mem.addr) - 32'h4;
	endproperty
	a_step: assert property (p_step) else $error("sp step");
	property p_jump;
		redirectValid |-> !busy && $past(memAck && !mem.we)
			&& redirectPc == $past(memRdata);
	endproperty
	a_jump: assert property (p_jump) else $error("jump");
	property p_mask;
		redirectValid && intRun_r && ackVector[7:4] == 4'h4 |->
			statusWord[7:4] == ackVector[3:0];
	endproperty
	a_mask: assert property (p_mask) else $error("mask");
	property p_nmi;
		redirectValid && intRun_r && ackVector == 8'h0b |->
			statusWord[7:4] == 4'hf;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi mask");
	property p_done;
		$rose(busy) |-> ##[3:60] redirectValid;
	endproperty
	a_done: assert property (p_done) else $error("hang");
	c_int: cover property (intAck);
	c_nmi: cover property (intAck && ackVector == 8'h0b);
	c_slot: cover property ($rose(busy) && $past(dec.inSlot));
endmodule : exception_unit_properties
bind exception_unit exception_unit_properties exception_unit_properties_i (
	.core_clk(core_clk),
	.reset(reset),
	.dec(dec),
	.mem(mem),
	.memAck(memAck),
	.memRdata(memRdata),
	.intAck(intAck),
	.ackVector(ackVector),
	.busy(busy),
	.redirectValid(redirectValid),
	.redirectPc(redirectPc),
	.statusWord(statusWord)
);

// [sim/mem_model.sv]
// Memory responder for stacking writes and vector fetches
`timescale 1ns/1ps
module mem_model (
	// Clock, reset and pacing
	input wire logic core_clk,
	input wire logic reset,
	input wire logic slow,
	// Memory port
	input wire exc_pkg::mem_req_t mem,
	output logic memAck,
	output logic [31:0] memRdata
);
	logic [31:0] wrA[$];
	logic [31:0] wrD[$];
	logic [1:0] dly_r;
	logic hit;
	assign hit = !reset && !memAck && mem.req && dly_r == 2'h0;
	always_ff @(posedge core_clk) begin
		memAck <= hit;
		if (reset || memAck || !mem.req) begin
			dly_r <= slow ? 2'h3 : 2'h0;
		end else if (!hit) begin
			dly_r <= dly_r - 2'h1;
		end
		if (hit && mem.we) begin
			wrA.push_back(mem.addr);
			wrD.push_back(mem.wdata);
		end
	end
	// Stale read data inverts every cycle, so a sample one cycle late shows
	always_ff @(posedge core_clk) begin
		if (hit && !mem.we) begin
			memRdata <= ~mem.addr;
		end else begin
			memRdata <= reset ? '0 : ~memRdata;
		end
	end
endmodule : mem_model

// [sim/interrupt_and_trap_exception_unit_test.sv]
// Self-checking bench for the exception unit
`timescale 1ns/1ps
module interrupt_and_trap_exception_unit_test;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr;
	logic nmiPin, userBreakReq, debugInterfaceReq, memAck, intAck;
	logic busy, redirectValid, slow, err;
	logic [3:0] encodedLevelPins, extLineReq;
	logic [7:0] periphReq, ackVector;
	logic [31:0] paddr, pwdata, prdata, redirectPc, statusWord;
	logic [31:0] memRdata, rd, sp, sr;
	exc_pkg::dec_t dec;
	exc_pkg::mem_req_t mem;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	exception_unit exception_unit_i (
		.core_clk(core_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.nmiPin(nmiPin), .userBreakReq(userBreakReq),
		.debugInterfaceReq(debugInterfaceReq),
		.encodedLevelPins(encodedLevelPins),
		.extLineReq(extLineReq), .periphReq(periphReq),
		.dec(dec), .mem(mem), .memAck(memAck), .memRdata(memRdata),
		.intAck(intAck), .ackVector(ackVector), .busy(busy),
		.redirectValid(redirectValid), .redirectPc(redirectPc),
		.statusWord(statusWord)
	);
	mem_model mem_model_i (
		.core_clk(core_clk), .reset(reset), .slow(slow),
		.mem(mem), .memAck(memAck), .memRdata(memRdata)
	);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic run(input logic [7:0] v, input logic [31:0] r,
		input logic [3:0] m);
		do @(posedge core_clk); while (redirectValid !== 1'b1);
		check(redirectPc, ~(32'h2000 + {22'h0, v, 2'h0}));
		check(mem_model_i.wrA[0], sp - 32'h4);
		check(mem_model_i.wrD[0], sr);
		check(mem_model_i.wrA[1], sp - 32'h8);
		check(mem_model_i.wrD[1], r);
		check(statusWord, {24'h0, m, 4'h0});
		sp = sp - 32'h8;
		sr = {24'h0, m, 4'h0};
		mem_model_i.wrA.delete();
		mem_model_i.wrD.delete();
	endtask : run
	task automatic irq(input logic [7:0] v, input logic [3:0] m);
		dec <= '{valid: 1'b1, pc: 32'h400, default: '0};
		do @(posedge core_clk); while (intAck !== 1'b1);
		check({24'h0, ackVector}, {24'h0, v});
		dec.valid <= 1'b0;
		run(v, 32'h400, m);
	endtask : irq
	task automatic idle();
		dec <= '{valid: 1'b1, pc: 32'h400, default: '0};
		repeat (6) begin
			@(posedge core_clk);
			check({31'h0, busy}, 32'h0);
		end
		dec.valid <= 1'b0;
	endtask : idle
	task automatic setmask(input logic [3:0] m);
		sr = {24'h0, m, 4'h0};
		apb(1'b1, 8'h00, sr);
	endtask : setmask
	task automatic instr(input exc_pkg::dec_t d, input logic [7:0] v,
		input logic [31:0] r);
		dec <= d;
		@(posedge core_clk);
		dec.valid <= 1'b0;
		run(v, r, sr[7:4]);
	endtask : instr
	task automatic test_levels();
		for (int l = 1; l < 16; l++) begin
			setmask(4'(l));
			encodedLevelPins <= 4'(l);
			idle();
			setmask(4'(l - 1));
			irq(8'h40 + 8'(l), 4'(l));
			encodedLevelPins <= 4'h0;
		end
		$display("levels done");
	endtask : test_levels
	task automatic test_fixed();
		encodedLevelPins <= 4'h7;
		userBreakReq <= 1'b1;
		debugInterfaceReq <= 1'b1;
		nmiPin <= 1'b1;
		irq(8'h0b, 4'hf);
		nmiPin <= 1'b0;
		idle();
		setmask(4'he);
		irq(8'h0c, 4'hf);
		userBreakReq <= 1'b0;
		setmask(4'he);
		irq(8'h0e, 4'hf);
		debugInterfaceReq <= 1'b0;
		setmask(4'h0);
		irq(8'h47, 4'h7);
		encodedLevelPins <= 4'h0;
		$display("fixed done");
	endtask : test_fixed
	task automatic test_lines();
		slow <= 1'b1;
		apb(1'b1, 8'h0c, 32'h900);
		apb(1'b1, 8'h10, 32'hc);
		setmask(4'h0);
		encodedLevelPins <= 4'h3;
		extLineReq <= 4'h4;
		periphReq <= 8'h01;
		irq(8'h60, 4'hc);
		periphReq <= 8'h00;
		setmask(4'h0);
		irq(8'h52, 4'h9);
		extLineReq <= 4'h0;
		setmask(4'h0);
		irq(8'h43, 4'h3);
		encodedLevelPins <= 4'h0;
		slow <= 1'b0;
		$display("lines done");
	endtask : test_lines
	task automatic test_instr();
		setmask(4'h0);
		encodedLevelPins <= 4'h9;
		instr('{valid: 1'b1, trap: 1'b1, pcWrite: 1'b1, trapVec: 8'h21,
			nextPc: 32'h502, default: '0}, 8'h21, 32'h502);
		irq(8'h49, 4'h9);
		encodedLevelPins <= 4'h0;
		instr('{valid: 1'b1, undefined: 1'b1, inSlot: 1'b1,
			slotTarget: 32'h800, default: '0}, 8'h06, 32'h800);
		instr('{valid: 1'b1, pcWrite: 1'b1, inSlot: 1'b1,
			slotTarget: 32'h900, default: '0}, 8'h06, 32'h900);
		instr('{valid: 1'b1, trap: 1'b1, pcWrite: 1'b1, inSlot: 1'b1,
			slotTarget: 32'ha00, default: '0}, 8'h06, 32'ha00);
		instr('{valid: 1'b1, undefined: 1'b1, pc: 32'h700,
			default: '0}, 8'h04, 32'h700);
		$display("instr done");
	endtask : test_instr
	task automatic test_readback();
		apb(1'b0, 8'h04, 32'h0);
		check(rd, sp);
		apb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h2000);
		apb(1'b0, 8'h0c, 32'h0);
		check(rd, 32'h900);
		apb(1'b0, 8'h10, 32'h0);
		check(rd, 32'hc);
		apb(1'b0, 8'h14, 32'h0);
		check(rd, {8'h0, 8'h49, 8'h0, sr[7:0]});
		$display("readback done");
	endtask : test_readback
	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, nmiPin, userBreakReq} = '0;
		{debugInterfaceReq, slow, encodedLevelPins, extLineReq} = '0;
		{paddr, pwdata, periphReq} = '0;
		dec = '0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'hf0);
		apb(1'b0, 8'h40, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, 8'h04, 32'h1000);
		apb(1'b1, 8'h08, 32'h2000);
		sp = 32'h1000;
		sr = 32'hf0;
		$display("regs done");
		test_levels();
		test_fixed();
		test_lines();
		test_instr();
		test_readback();
		end_sim();
	end
endmodule : interrupt_and_trap_exception_unit_test
